// >>> shared/rfdss_regs.svh
// Purpose: Register indices, field positions, codes and reset values of the driver source select block.
// Assumes: Byte address on APB is four times the register index.
// Notes:   Definitions only.
`ifndef RFDSS_REGS_SVH
`define RFDSS_REGS_SVH
`define RFDSS_IDX_CTRL       6'h14
`define RFDSS_IDX_DEPTH      6'h15
`define RFDSS_IDX_SRC        6'h16
`define RFDSS_IDX_STATUS     6'h30
`define RFDSS_IDX_TSEL       6'h31
`define RFDSS_RST_CTRL       8'h00
`define RFDSS_RST_DEPTH      8'h00
`define RFDSS_RST_SRC        8'h10
`define RFDSS_RST_TSEL       8'h00
`define RFDSS_MASK_CTRL      8'hfb
`define RFDSS_MASK_DEPTH     8'h40
`define RFDSS_MASK_SRC       8'h3f
`define RFDSS_MASK_TSEL      8'h07
`define RFDSS_BIT_B_INV_ON   7
`define RFDSS_BIT_A_INV_ON   6
`define RFDSS_BIT_B_INV_OFF  5
`define RFDSS_BIT_A_INV_OFF  4
`define RFDSS_BIT_B_CW       3
`define RFDSS_BIT_B_EN       1
`define RFDSS_BIT_A_EN       0
`define RFDSS_BIT_FORCE      6
`define RFDSS_DRV_HIZ        2'h0
`define RFDSS_DRV_ENCODER    2'h1
`define RFDSS_DRV_AUX_IN     2'h2
`define RFDSS_DRV_HIGH       2'h3
`define RFDSS_AUX_HIZ        4'h0
`define RFDSS_AUX_LOW        4'h1
`define RFDSS_AUX_HIGH       4'h2
`define RFDSS_AUX_TEST       4'h3
`define RFDSS_AUX_ENVELOPE   4'h4
`define RFDSS_AUX_TX_SERIAL  4'h5
`define RFDSS_AUX_RX_SERIAL  4'h7
`endif

// >>> shared/rfdss_pkg.sv
// Purpose: Types shared by the driver source select block.
// Assumes: Eight-bit registers carried on a 32-bit APB.
// Notes:   Constants live in rfdss_regs.svh.
package rfdss_pkg;
  typedef logic [7:0]  rfdss_byte_t;
  typedef logic [31:0] rfdss_word_t;
  typedef logic [7:0]  rfdss_addr_t;
endpackage

// >>> design/rfdss_top.sv
// Purpose: Selects and conditions the two antenna driver pins and the auxiliary modulation output.
// Assumes: Envelope, serial data and test bus come from logic on clk; carrier and aux input are pins.
// Notes:   Pin levels are registered; a pin input reaches the pins three edges after it changes.
// Behaviour
// - Driver B inverted while disabled, bit 5
// - Driver A inverted while disabled, bit 4
// - Bits 7/6 invert enabled driver B/A
// - Bit 3 gives enabled driver B (bit 1 set) unmodulated carrier
// - Bit 1 enables modulated carrier on B
// - Bit 0 enables modulated carrier on A
// - Depth bit 6 forces full-depth modulation
// - Depth register resets to zero
// - Source 00 puts both drivers high-Z
// - Source 01 feeds internal encoder envelope
// - Source 10 feeds envelope from aux input
// - Source 11 feeds constant high, inversions apply
// - Source register resets to 10h
// - Aux codes 0000/0001/0010: high-Z, low, high
// - Aux code 0011 routes selected test bit
// - Aux 0100 envelope, 0101 raw transmit stream
// - Aux 0111 outputs decoded receive stream
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "rfdss_regs.svh"
module rfdss_top (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire rfdss_pkg::rfdss_addr_t paddr,
  input  wire rfdss_pkg::rfdss_word_t pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output rfdss_pkg::rfdss_word_t    prdata,
  input  wire logic                 carrier_in,
  input  wire logic                 aux_modulation_input,
  input  wire logic                 encoder_envelope,
  input  wire logic                 tx_serial_data,
  input  wire logic                 rx_decoded_data,
  input  wire rfdss_pkg::rfdss_byte_t test_bus,
  input  wire logic                 soft_power_down,
  output logic                      antenna_driver_a,
  output logic                      antenna_driver_a_oe_n,
  output logic                      antenna_driver_b,
  output logic                      antenna_driver_b_oe_n,
  output logic                      aux_modulation_output,
  output logic                      aux_modulation_output_oe_n,
  output logic                      force_full_depth_modulation
);
  import rfdss_pkg::*;

  function automatic logic idx_hit(input rfdss_addr_t a, input logic [5:0] idx);
    idx_hit = (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  rfdss_byte_t ctrl_r, ctrl_nxt;
  rfdss_byte_t depth_r, depth_nxt;
  rfdss_byte_t src_r, src_nxt;
  rfdss_byte_t tsel_r, tsel_nxt;
  rfdss_word_t rdata_r, rdata_nxt;
  logic        err_r, err_nxt;
  logic [1:0]  car_sync_r, aux_sync_r;
  logic        drv_a_r, drv_a_nxt, drv_a_oe_n_r, drv_a_oe_n_nxt;
  logic        drv_b_r, drv_b_nxt, drv_b_oe_n_r, drv_b_oe_n_nxt;
  logic        aux_r, aux_nxt, aux_oe_n_r, aux_oe_n_nxt;
  logic        wr_en, setup;
  logic        mapped;
  logic        carrier_s, aux_in_s, env;
  logic [1:0]  driver_source_field;
  logic [3:0]  aux_output_source_field;
  logic [2:0]  test_bus_bit_select;
  logic        drv_a_invert_when_on, drv_a_invert_when_off, drv_a_modulated_enable;
  logic        drv_b_invert_when_on, drv_b_invert_when_off, drv_b_modulated_enable;
  logic        drv_b_continuous_carrier;

  assign drv_b_invert_when_on     = ctrl_r[`RFDSS_BIT_B_INV_ON];
  assign drv_a_invert_when_on     = ctrl_r[`RFDSS_BIT_A_INV_ON];
  assign drv_b_invert_when_off    = ctrl_r[`RFDSS_BIT_B_INV_OFF];
  assign drv_a_invert_when_off    = ctrl_r[`RFDSS_BIT_A_INV_OFF];
  assign drv_b_continuous_carrier = ctrl_r[`RFDSS_BIT_B_CW];
  assign drv_b_modulated_enable   = ctrl_r[`RFDSS_BIT_B_EN];
  assign drv_a_modulated_enable   = ctrl_r[`RFDSS_BIT_A_EN];
  assign driver_source_field      = src_r[5:4];
  assign aux_output_source_field  = src_r[3:0];
  assign test_bus_bit_select      = tsel_r[2:0];
  assign carrier_s                = car_sync_r[1];
  assign aux_in_s                 = aux_sync_r[1];

  // Every access completes in its first access cycle; read data is latched in the setup cycle.
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && !pslverr;
  assign mapped  = idx_hit(paddr, `RFDSS_IDX_CTRL) || idx_hit(paddr, `RFDSS_IDX_DEPTH) ||
                   idx_hit(paddr, `RFDSS_IDX_SRC) || idx_hit(paddr, `RFDSS_IDX_TSEL) ||
                   (idx_hit(paddr, `RFDSS_IDX_STATUS) && !pwrite);
  assign pready  = psel && penable;
  assign pslverr = psel && penable && err_r;
  assign prdata  = rdata_r;

  always_comb begin
    ctrl_nxt  = ctrl_r;
    depth_nxt = depth_r;
    src_nxt   = src_r;
    tsel_nxt  = tsel_r;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      err_nxt   = !mapped;
      rdata_nxt = 32'h0000_0000;
      if (idx_hit(paddr, `RFDSS_IDX_CTRL)) rdata_nxt[7:0] = ctrl_r;
      if (idx_hit(paddr, `RFDSS_IDX_DEPTH)) rdata_nxt[7:0] = depth_r;
      if (idx_hit(paddr, `RFDSS_IDX_SRC)) rdata_nxt[7:0] = src_r;
      if (idx_hit(paddr, `RFDSS_IDX_TSEL)) rdata_nxt[7:0] = tsel_r;
      if (idx_hit(paddr, `RFDSS_IDX_STATUS)) begin
        rdata_nxt[5:0] = {aux_r, aux_oe_n_r, drv_b_r, drv_b_oe_n_r, drv_a_r, drv_a_oe_n_r};
      end
    end
    if (wr_en) begin
      // Reserved bits are masked off so they always read back as zero.
      if (idx_hit(paddr, `RFDSS_IDX_CTRL)) ctrl_nxt = pwdata[7:0] & `RFDSS_MASK_CTRL;
      if (idx_hit(paddr, `RFDSS_IDX_DEPTH)) depth_nxt = pwdata[7:0] & `RFDSS_MASK_DEPTH;
      if (idx_hit(paddr, `RFDSS_IDX_SRC)) src_nxt = pwdata[7:0] & `RFDSS_MASK_SRC;
      if (idx_hit(paddr, `RFDSS_IDX_TSEL)) tsel_nxt = pwdata[7:0] & `RFDSS_MASK_TSEL;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r  <= `RFDSS_RST_CTRL;
      depth_r <= `RFDSS_RST_DEPTH;
      src_r   <= `RFDSS_RST_SRC;
      tsel_r  <= `RFDSS_RST_TSEL;
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      depth_r <= depth_nxt;
      src_r   <= src_nxt;
      tsel_r  <= tsel_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      car_sync_r <= 2'h0;
      aux_sync_r <= 2'h0;
    end else begin
      car_sync_r <= {car_sync_r[0], carrier_in};
      aux_sync_r <= {aux_sync_r[0], aux_modulation_input};
    end
  end

  always_comb begin
    unique case (driver_source_field)
      `RFDSS_DRV_ENCODER: env = encoder_envelope;
      `RFDSS_DRV_AUX_IN:  env = aux_in_s;
      `RFDSS_DRV_HIGH:    env = 1'b1;
      `RFDSS_DRV_HIZ:     env = 1'b0;
    endcase
  end

  // A disabled driver shows only its off-state inversion level; it never carries the carrier.
  always_comb begin
    drv_a_nxt      = drv_a_modulated_enable ? ((carrier_s & env) ^ drv_a_invert_when_on)
                                            : drv_a_invert_when_off;
    drv_b_nxt      = drv_b_modulated_enable ? (((carrier_s & (env | drv_b_continuous_carrier)))
                                               ^ drv_b_invert_when_on)
                                            : drv_b_invert_when_off;
    // Soft power-down does not float the drivers unless high-Z is the selected source.
    drv_a_oe_n_nxt = (driver_source_field == `RFDSS_DRV_HIZ);
    drv_b_oe_n_nxt = (driver_source_field == `RFDSS_DRV_HIZ);
    if (soft_power_down) begin
      drv_a_nxt = drv_a_invert_when_off;
      drv_b_nxt = drv_b_invert_when_off;
    end
    if (drv_a_oe_n_nxt) begin
      drv_a_nxt = 1'b0;
      drv_b_nxt = 1'b0;
    end
  end

  // Reserved aux codes float the pin rather than show an undefined signal.
  always_comb begin
    aux_nxt      = 1'b0;
    aux_oe_n_nxt = 1'b0;
    unique case (aux_output_source_field)
      `RFDSS_AUX_LOW:       aux_nxt = 1'b0;
      `RFDSS_AUX_HIGH:      aux_nxt = 1'b1;
      `RFDSS_AUX_TEST:      aux_nxt = test_bus[test_bus_bit_select];
      `RFDSS_AUX_ENVELOPE:  aux_nxt = encoder_envelope;
      `RFDSS_AUX_TX_SERIAL: aux_nxt = tx_serial_data;
      `RFDSS_AUX_RX_SERIAL: aux_nxt = rx_decoded_data;
      default:              aux_oe_n_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drv_a_r      <= 1'b0;
      drv_a_oe_n_r <= 1'b1;
      drv_b_r      <= 1'b0;
      drv_b_oe_n_r <= 1'b1;
      aux_r        <= 1'b0;
      aux_oe_n_r   <= 1'b1;
    end else begin
      drv_a_r      <= drv_a_nxt;
      drv_a_oe_n_r <= drv_a_oe_n_nxt;
      drv_b_r      <= drv_b_nxt;
      drv_b_oe_n_r <= drv_b_oe_n_nxt;
      aux_r        <= aux_nxt;
      aux_oe_n_r   <= aux_oe_n_nxt;
    end
  end

  assign antenna_driver_a            = drv_a_r;
  assign antenna_driver_a_oe_n       = drv_a_oe_n_r;
  assign antenna_driver_b            = drv_b_r;
  assign antenna_driver_b_oe_n       = drv_b_oe_n_r;
  assign aux_modulation_output       = aux_r;
  assign aux_modulation_output_oe_n  = aux_oe_n_r;
  assign force_full_depth_modulation = depth_r[`RFDSS_BIT_FORCE];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = !soft_power_down && !psel;

  sequence ctrl_write_s;
    psel && !penable && pwrite && idx_hit(paddr, `RFDSS_IDX_CTRL) ##1 psel && penable;
  endsequence
  sequence depth_write_s;
    psel && !penable && pwrite && idx_hit(paddr, `RFDSS_IDX_DEPTH) ##1 psel && penable;
  endsequence

  drv_b_off_a: assert property (quiet && !drv_b_modulated_enable && driver_source_field != 2'h0
    |=> antenna_driver_b == $past(drv_b_invert_when_off) && !antenna_driver_b_oe_n)
    else $error("Disabled driver B level wrong.");
  drv_a_off_a: assert property (quiet && !drv_a_modulated_enable && driver_source_field != 2'h0
    |=> antenna_driver_a == $past(drv_a_invert_when_off))
    else $error("Disabled driver A level wrong.");
  drv_high_on_a: assert property (quiet && drv_a_modulated_enable && driver_source_field == 2'h3
    |=> antenna_driver_a == ($past(carrier_s) ^ $past(drv_a_invert_when_on)))
    else $error("Driver A on-state inversion wrong.");
  drv_b_cw_a: assert property (quiet && drv_b_modulated_enable && drv_b_continuous_carrier
    && driver_source_field == 2'h1 |=> antenna_driver_b == ($past(carrier_s) ^ $past(drv_b_invert_when_on)))
    else $error("Continuous carrier on driver B wrong.");
  drv_b_mod_a: assert property (quiet && drv_b_modulated_enable && !drv_b_continuous_carrier
    && driver_source_field == 2'h2 |=> antenna_driver_b ==
    (($past(carrier_s) & $past(aux_in_s)) ^ $past(drv_b_invert_when_on)))
    else $error("Driver B modulation from aux input wrong.");
  drv_a_mod_a: assert property (quiet && drv_a_modulated_enable && driver_source_field == 2'h1
    |=> antenna_driver_a == (($past(carrier_s) & $past(encoder_envelope)) ^ $past(drv_a_invert_when_on)))
    else $error("Driver A encoder modulation wrong.");
  force_bit_a: assert property (depth_write_s |=> force_full_depth_modulation == $past(pwdata[6]))
    else $error("Force full-depth bit not written.");
  ctrl_mask_a: assert property (ctrl_write_s |=> ctrl_r == ($past(pwdata[7:0]) & 8'hfb))
    else $error("Control write or reserved mask wrong.");
  reset_vals_a: assert property (disable iff (1'b0) sys_rst |=> depth_r == 8'h00 && src_r == 8'h10)
    else $error("Reset values wrong.");
  hiz_drivers_a: assert property (driver_source_field == 2'h0 [*2]
    |-> antenna_driver_a_oe_n && antenna_driver_b_oe_n)
    else $error("Drivers not high-Z on source 00.");
  aux_const_a: assert property (aux_output_source_field inside {4'h0, 4'h1, 4'h2}
    |=> aux_modulation_output_oe_n == ($past(aux_output_source_field) == 4'h0)
    && aux_modulation_output == ($past(aux_output_source_field) == 4'h2))
    else $error("Aux constant codes wrong.");
  aux_test_a: assert property (aux_output_source_field == 4'h3
    |=> aux_modulation_output == $past(test_bus[test_bus_bit_select]))
    else $error("Aux test bus routing wrong.");
  aux_rx_a: assert property (aux_output_source_field == 4'h7
    |=> aux_modulation_output == $past(rx_decoded_data) && !aux_modulation_output_oe_n)
    else $error("Aux receive stream routing wrong.");
endmodule

// >>> tb/rfdss_antenna_model.sv
// Purpose: Antenna side of the block: the carrier pin and the aux envelope pin.
// Assumes: The carrier runs free at 13.56 MHz while enabled; otherwise it holds a chosen level.
// Notes:   The carrier is asynchronous to clk, so the bench checks held levels after the sync delay.
`timescale 1ns/10ps
module rfdss_antenna_model (
  input  wire logic car_run,
  input  wire logic car_level,
  input  wire logic env_level,
  output logic      carrier_in,
  output logic      aux_modulation_input
);
  initial begin
    carrier_in = 1'b0;
    forever #36.87 if (car_run) carrier_in = !carrier_in;
  end
  always @(car_run or car_level) begin
    if (!car_run) carrier_in = car_level;
  end
  assign aux_modulation_input = env_level;
endmodule

// >>> tb/test_rf_driver_source_select.sv
// Purpose: Self-checking bench for the driver source select block.
// Assumes: Pin inputs reach the pins within six edges; APB answers within 16 cycles of the access phase.
// Notes:   Drivers queue expected values; two watchers pop and compare them.
`timescale 1ns/10ps
`include "rfdss_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module test_rf_driver_source_select;
  import rfdss_pkg::*;
  typedef struct {string nm; logic [32:0] v;} rfdss_note_s;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, car_run, car_level, env_level, p;
  logic        carrier_in, aux_in, enc, txd, rxd, spd, drv_a, drv_a_oe_n, drv_b, drv_b_oe_n, aux, aux_oe_n, frc;
  rfdss_addr_t paddr;
  rfdss_word_t pwdata, prdata;
  rfdss_byte_t tbus;
  logic [32:0] seen;
  logic [31:0] xs_state = 32'h87fc;
  logic [5:0]  idx_l [4] = '{`RFDSS_IDX_CTRL, `RFDSS_IDX_DEPTH, `RFDSS_IDX_SRC, `RFDSS_IDX_TSEL};
  rfdss_byte_t msk_l [4] = '{`RFDSS_MASK_CTRL, `RFDSS_MASK_DEPTH, `RFDSS_MASK_SRC, `RFDSS_MASK_TSEL};
  rfdss_note_s notes[$];
  int          bad_count, total_checks, cnt;
  event        pin_ev;
  rfdss_top u_rfdss_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .carrier_in, .aux_modulation_input(aux_in), .encoder_envelope(enc), .tx_serial_data(txd),
    .rx_decoded_data(rxd), .test_bus(tbus), .soft_power_down(spd), .antenna_driver_a(drv_a),
    .antenna_driver_a_oe_n(drv_a_oe_n), .antenna_driver_b(drv_b), .antenna_driver_b_oe_n(drv_b_oe_n),
    .aux_modulation_output(aux), .aux_modulation_output_oe_n(aux_oe_n), .force_full_depth_modulation(frc));
  rfdss_antenna_model u_rfdss_antenna_model (.car_run, .car_level, .env_level, .carrier_in,
    .aux_modulation_input(aux_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  // Read data is only meaningful on a good read, so errors and writes compare the error flag alone.
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      `CHK(notes[0].nm, notes[0].v, {pslverr, pwrite || pslverr ? 32'h0 : prdata})
      void'(notes.pop_front());
    end
  end
  always @(pin_ev) begin
    `CHK(notes[0].nm, notes[0].v, seen)
    void'(notes.pop_front());
  end
  function automatic logic [31:0] xs();
    xs_state ^= xs_state << 13;
    xs_state ^= xs_state >> 17;
    xs_state ^= xs_state << 5;
    return xs_state;
  endfunction
  // A floating pin has no defined level, so its level bit is masked to zero.
  function automatic logic [32:0] pins();
    return {26'h0, frc, aux & !aux_oe_n, aux_oe_n, drv_b & !drv_b_oe_n, drv_b_oe_n, drv_a & !drv_a_oe_n, drv_a_oe_n};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input rfdss_word_t d, input string nm, input logic [32:0] e);
    int n;
    @(posedge clk);
    notes.push_back('{nm, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [5:0] i, input rfdss_word_t d);
    apb(1'b1, i, d, "write", 33'h0);
  endtask
  task automatic rd(input logic [5:0] i, input string nm, input rfdss_byte_t e);
    apb(1'b0, i, 32'h0, nm, {25'h0, e});
  endtask
  task automatic pin_chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    notes.push_back('{nm, e});
    seen = s;
    ->pin_ev;
  endtask
  task automatic run_case(input logic [31:0] r);
    logic [7:0] c;
    logic [1:0] d;
    logic [3:0] x;
    logic       e, a, b, m, mo;
    logic [32:0] ex;
    {c, d, x} = {r[7:0] & `RFDSS_MASK_CTRL, r[9:8], r[13:10]};
    wr(`RFDSS_IDX_CTRL, {24'h0, r[7:0]});
    {car_level, env_level, enc, txd, rxd, tbus, spd} <= r[27:14];
    wr(`RFDSS_IDX_SRC, {24'h0, r[31:30], d, x});
    wr(`RFDSS_IDX_DEPTH, {24'h0, r[31:24]});
    wr(`RFDSS_IDX_TSEL, {29'h0, r[30:28]});
    repeat (6) @(posedge clk);
    #1;
    e = d == 2'h1 ? enc : d == 2'h2 ? env_level : 1'b1;
    a = !c[0] || spd ? c[4] : (car_level & e) ^ c[6];
    b = !c[1] || spd ? c[5] : (car_level & (e | c[3])) ^ c[7];
    mo = !(x inside {[4'h1:4'h5], 4'h7});
    m = x == 4'h2 || x == 4'h3 && tbus[r[30:28]] || x == 4'h4 && enc || x == 4'h5 && txd || x == 4'h7 && rxd;
    ex = {26'h0, r[30], m, mo, b && d != 0, d == 0, a && d != 0, d == 0};
    pin_chk("pins", ex, pins());
    rd(`RFDSS_IDX_SRC, "source readback", {2'b00, d, x});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, car_run, car_level, env_level, enc, txd, rxd, tbus, spd} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    pin_chk("reset pins", 33'h10, pins());
    rd(`RFDSS_IDX_DEPTH, "depth reset", `RFDSS_RST_DEPTH);
    rd(`RFDSS_IDX_SRC, "source reset", `RFDSS_RST_SRC);
    // Status mirrors the pin registers: after reset only the aux pin floats.
    rd(`RFDSS_IDX_STATUS, "status reset", 8'h10);
    $display("test reset values done");
    foreach (idx_l[i]) begin
      wr(idx_l[i], 32'hffffffff);
      rd(idx_l[i], "reserved bits", msk_l[i]);
    end
    pin_chk("force level", 33'h1, {32'h0, frc});
    apb(1'b0, 6'h20, 32'h0, "unmapped read", {1'b1, 32'h0});
    apb(1'b1, `RFDSS_IDX_STATUS, 32'h0, "status write", {1'b1, 32'h0});
    $display("test reserved and unmapped done");
    repeat (48) run_case(xs());
    $display("test random settings done");
    wr(`RFDSS_IDX_CTRL, 32'h1);
    wr(`RFDSS_IDX_SRC, 32'h30);
    spd <= 1'b0;
    car_run <= 1'b1;
    cnt = 0;
    repeat (80) begin
      p = drv_a;
      @(posedge clk);
      #1 cnt += int'(drv_a !== p);
    end
    pin_chk("carrier toggles", 33'h1, {32'h0, cnt > 4});
    $display("test running carrier done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`RFDSS_IDX_SRC, "source after reset", `RFDSS_RST_SRC);
    rd(`RFDSS_IDX_DEPTH, "depth after reset", `RFDSS_RST_DEPTH);
    $display("test second reset done");
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
